// File: logic/fitp_sync.sv
/*
  three-stage synchroniser with agreement filter for asynchronous pin inputs.
  assumes a single clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps

module fitp_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // pins
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  initial begin
    if (WIDTH < 1) $error("fitp_sync: WIDTH must be at least one");
  end

  // only stages two and three are compared; stage one feeds stage two alone
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        out_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : out_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg  <= RST_VAL;
      s2_reg  <= RST_VAL;
      s3_reg  <= RST_VAL;
      out_reg <= RST_VAL;
    end else begin
      s1_reg  <= i_async;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign o_sync = out_reg;

endmodule

// File: logic/fitp_top.sv
/*
  flag pins, external interrupt request inputs and timer-expired pin logic,
  with a small register port and two level interrupt outputs.
  assumes an asynchronous active-low reset, a 100 MHz clock and a board that
  works out pin levels from the output enables.
*/
// Added by the designer: the strobed register port and the register offsets.
// Notes on behaviour
// - each flag pin is input or output on its own; inputs readable as conditions
// - after reset all four flag pins are inputs with drivers off
// - an asserted, enabled and unmasked interrupt request raises the core interrupt
// - each request input selects edge or level detection by itself
// - requests are disabled after reset unless the boot strap enables them
// - each timer expiry drives the expired output for four clocks; an expiry inside the pulse restarts the four
// - during reset the expired pin is an input strap, sampled not driven
`timescale 1ns/1ps

`include "fitp_regs.svh"

module fitp_top
  import fitp_pkg::*;
#(
  parameter int NFLAG = 4,
  parameter int NIRQ  = 4
) (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // register port
  input  wire logic [3:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // flag pins
  input  wire logic [3:0]  I_FLAG,
  output logic      [3:0]  O_FLAG,
  output logic      [3:0]  O_FLAG_OE,
  // interrupt request inputs, active low
  input  wire logic [3:0]  I_IRQ_N,
  output logic             O_CORE_IRQ,
  // timer-expired pin
  input  wire logic        I_TMR_EXP,
  output logic             O_TMR_EXP,
  output logic             O_TMR_EXP_OE,
  output logic             O_STRAP_IRQ_BOOT,
  // event interrupt
  output logic             O_IRQ
);

  initial begin
    if (NFLAG != 4 || NIRQ != 4) $error("fitp_top: four flags and four requests only");
  end

  fitp_bus_req_type  req;
  fitp_flag_cfg_type flag_reg, flag_next;
  logic [3:0]  flag_in;
  logic [3:0]  irq_act;
  logic [3:0]  irq_prev_reg, irq_prev_next;
  logic [3:0]  irq_en_reg, irq_en_next;
  logic [3:0]  irq_edge_reg, irq_edge_next;
  logic [3:0]  irq_stat_reg, irq_stat_next;
  logic [3:0]  irq_mask_reg, irq_mask_next;
  logic [1:0]  evt_stat_reg, evt_stat_next;
  logic [1:0]  evt_mask_reg, evt_mask_next;
  logic        tmr_run_reg, tmr_run_next;
  logic [31:0] tmr_load_reg, tmr_load_next;
  logic [31:0] tmr_cnt_reg, tmr_cnt_next;
  logic [2:0]  pulse_cnt_reg, pulse_cnt_next;
  fitp_tmr_state_type st_reg, st_next;
  logic        strap_reg, strap_next;
  logic        strap_done_reg, strap_done_next;
  logic [3:0]  irq_pend;
  logic [3:0]  irq_set;
  logic [1:0]  evt_set;
  logic        tmr_expire;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic        core_irq_reg, irq_reg;
  logic [3:0]  flag_o_reg, flag_oe_reg;
  logic        tmr_o_reg, tmr_oe_reg;

  assign req = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

  fitp_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_flag_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_async (I_FLAG),
    .o_sync  (flag_in)
  );

  logic [3:0] irq_lvl_n;
  fitp_sync #(.WIDTH(4), .RST_VAL(4'hf)) u_irq_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_async (I_IRQ_N),
    .o_sync  (irq_lvl_n)
  );
  assign irq_act = ~irq_lvl_n;

  // strap: pin is only a strap until the first clock after release
  logic strap_sync;
  // strap sampling while reset is held
  // kept out of reset: a reset chain would only ever hand over its reset value
  fitp_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_strap_sync (
    .i_clk   (I_CLK),
    .i_rst_n (1'b1),
    .i_async (I_TMR_EXP),
    .o_sync  (strap_sync)
  );

  // interrupt detection and register state
  always_comb begin
    flag_next     = flag_reg;
    irq_en_next   = irq_en_reg;
    irq_edge_next = irq_edge_reg;
    irq_mask_next = irq_mask_reg;
    evt_mask_next = evt_mask_reg;
    tmr_run_next  = tmr_run_reg;
    tmr_load_next = tmr_load_reg;
    strap_next      = strap_reg;
    strap_done_next = strap_done_reg;
    irq_prev_next = irq_act;
    for (int i = 0; i < 4; i++) begin
      irq_set[i] = irq_en_reg[i] & (irq_edge_reg[i] ? (irq_act[i] & ~irq_prev_reg[i]) : irq_act[i]);
    end
    evt_set = {|irq_set, tmr_expire};
    // set wins over a write-one clear
    irq_stat_next = irq_stat_reg;
    evt_stat_next = evt_stat_reg;
    if (req.wr && req.addr == `FITP_OFF_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~req.wdata[3:0];
    end
    if (req.wr && req.addr == `FITP_OFF_EVT_STAT) begin
      evt_stat_next = evt_stat_reg & ~req.wdata[1:0];
    end
    // level inputs stay pending while asserted
    irq_stat_next = irq_stat_next | irq_set;
    evt_stat_next = evt_stat_next | evt_set;
    // boot strap enables requests, taken once after release
    if (!strap_done_reg) begin
      strap_done_next = 1'b1;
      strap_next      = strap_sync;
      irq_en_next     = strap_sync ? `FITP_IRQ_EN_BOOT : `FITP_IRQ_EN_RST;
    end
    if (req.wr) begin
      case (req.addr)
        `FITP_OFF_FLAG_DIR: flag_next.dir = req.wdata[3:0];
        `FITP_OFF_FLAG_OUT: flag_next.out = req.wdata[3:0];
        `FITP_OFF_IRQ_EN:   irq_en_next   = req.wdata[3:0];
        `FITP_OFF_IRQ_EDGE: irq_edge_next = req.wdata[3:0];
        `FITP_OFF_IRQ_MASK: irq_mask_next = req.wdata[3:0];
        `FITP_OFF_EVT_MASK: evt_mask_next = req.wdata[1:0];
        `FITP_OFF_TMR_CTRL: tmr_run_next  = req.wdata[`FITP_TMR_RUN_BIT];
        `FITP_OFF_TMR_LOAD: tmr_load_next = req.wdata;
        default: ;
      endcase
    end
    irq_pend = irq_stat_reg & ~irq_mask_reg;
  end

  // read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (req.rd) begin
      case (req.addr)
        `FITP_OFF_FLAG_DIR: rdata_next = {28'h0, flag_reg.dir};
        `FITP_OFF_FLAG_OUT: rdata_next = {28'h0, flag_reg.out};
        `FITP_OFF_FLAG_IN:  rdata_next = {28'h0, flag_in};
        `FITP_OFF_IRQ_EN:   rdata_next = {28'h0, irq_en_reg};
        `FITP_OFF_IRQ_EDGE: rdata_next = {28'h0, irq_edge_reg};
        `FITP_OFF_IRQ_STAT: rdata_next = {28'h0, irq_stat_reg};
        `FITP_OFF_IRQ_MASK: rdata_next = {28'h0, irq_mask_reg};
        `FITP_OFF_TMR_CTRL: rdata_next = {31'h0, tmr_run_reg};
        `FITP_OFF_TMR_LOAD: rdata_next = tmr_load_reg;
        `FITP_OFF_STRAP:    rdata_next = {31'h0, strap_reg};
        `FITP_OFF_EVT_STAT: rdata_next = {30'h0, evt_stat_reg};
        `FITP_OFF_EVT_MASK: rdata_next = {30'h0, evt_mask_reg};
        default:            rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // timer zero and the expired pin
  always_comb begin
    st_next        = st_reg;
    tmr_cnt_next   = tmr_cnt_reg;
    pulse_cnt_next = pulse_cnt_reg;
    tmr_expire     = 1'b0;
    if (tmr_run_reg) begin
      if (tmr_cnt_reg == 32'h0000_0000) begin
        tmr_expire   = 1'b1;
        tmr_cnt_next = tmr_load_reg;
      end else begin
        tmr_cnt_next = tmr_cnt_reg - 32'h0000_0001;
      end
    end else begin
      tmr_cnt_next = tmr_load_reg;
    end
    case (st_reg)
      FITP_T_STRAP: st_next = FITP_T_IDLE;
      FITP_T_IDLE: begin
        if (tmr_expire) begin
          st_next        = FITP_T_PULSE;
          pulse_cnt_next = `FITP_TMR_PULSE_CYC;
        end
      end
      // four-cycle pulse; an expiry inside it restarts the pulse
      FITP_T_PULSE: begin
        if (tmr_expire) begin
          pulse_cnt_next = `FITP_TMR_PULSE_CYC;
        end else if (pulse_cnt_reg == 3'h1) begin
          st_next        = FITP_T_IDLE;
          pulse_cnt_next = 3'h0;
        end else begin
          pulse_cnt_next = pulse_cnt_reg - 3'h1;
        end
      end
      default: st_next = FITP_T_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      flag_reg       <= '{dir: `FITP_FLAG_DIR_RST, out: `FITP_FLAG_OUT_RST};
      irq_en_reg     <= `FITP_IRQ_EN_RST;
      irq_edge_reg   <= `FITP_IRQ_EDGE_RST;
      irq_stat_reg   <= 4'h0;
      irq_mask_reg   <= `FITP_MASK_RST;
      irq_prev_reg   <= 4'h0;
      evt_stat_reg   <= 2'h0;
      evt_mask_reg   <= 2'h0;
      tmr_run_reg    <= 1'b0;
      tmr_load_reg   <= `FITP_TMR_LOAD_RST;
      tmr_cnt_reg    <= `FITP_TMR_LOAD_RST;
      pulse_cnt_reg  <= 3'h0;
      st_reg         <= FITP_T_STRAP;
      strap_reg      <= 1'b0;
      strap_done_reg <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
      core_irq_reg   <= 1'b0;
      irq_reg        <= 1'b0;
      flag_o_reg     <= 4'h0;
      flag_oe_reg    <= 4'h0;
      tmr_o_reg      <= 1'b0;
      tmr_oe_reg     <= 1'b0;
    end else begin
      flag_reg       <= flag_next;
      irq_en_reg     <= irq_en_next;
      irq_edge_reg   <= irq_edge_next;
      irq_stat_reg   <= irq_stat_next;
      irq_mask_reg   <= irq_mask_next;
      irq_prev_reg   <= irq_prev_next;
      evt_stat_reg   <= evt_stat_next;
      evt_mask_reg   <= evt_mask_next;
      tmr_run_reg    <= tmr_run_next;
      tmr_load_reg   <= tmr_load_next;
      tmr_cnt_reg    <= tmr_cnt_next;
      pulse_cnt_reg  <= pulse_cnt_next;
      st_reg         <= st_next;
      strap_reg      <= strap_next;
      strap_done_reg <= strap_done_next;
      rdata_reg      <= rdata_next;
      // pending unmasked request to the core
      core_irq_reg   <= |irq_pend;
      irq_reg        <= |(evt_stat_reg & ~evt_mask_reg);
      flag_o_reg     <= flag_reg.out & flag_reg.dir;
      flag_oe_reg    <= flag_reg.dir;
      tmr_o_reg      <= (st_next == FITP_T_PULSE);
      tmr_oe_reg     <= (st_next != FITP_T_STRAP);
    end
  end

  assign O_RDATA          = rdata_reg;
  assign O_CORE_IRQ       = core_irq_reg;
  assign O_IRQ            = irq_reg;
  assign O_FLAG           = flag_o_reg;
  assign O_FLAG_OE        = flag_oe_reg;
  assign O_TMR_EXP        = tmr_o_reg;
  assign O_TMR_EXP_OE     = tmr_oe_reg;
  assign O_STRAP_IRQ_BOOT = strap_reg;

  // pulse width counter for checking
  logic [3:0] hi_cnt;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) hi_cnt <= 4'h0;
    else if (tmr_o_reg) hi_cnt <= hi_cnt + 4'h1;
    else hi_cnt <= 4'h0;
  end

  sequence expire_seen_s;
    tmr_expire && st_reg == FITP_T_IDLE;
  endsequence
  sequence pulse_four_s;
    ##1 tmr_o_reg [*4];
  endsequence

  pulse_width_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    expire_seen_s |-> pulse_four_s) else $error("expired pulse not four cycles");
  pulse_max_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (hi_cnt == 4'h4 && !$past(tmr_expire, 4)) |-> !tmr_o_reg || $past(tmr_expire, 1)
      || $past(tmr_expire, 2) || $past(tmr_expire, 3)) else $error("expired pulse too long");
  flag_dir_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (req.wr && req.addr == `FITP_OFF_FLAG_DIR) |-> ##2 O_FLAG_OE == $past(req.wdata[3:0], 2))
    else $error("flag direction not applied");
  flag_reset_a: assert property (@(posedge I_CLK)
    $rose(I_RST_N) |-> O_FLAG_OE == 4'h0) else $error("flag driven after reset");
  core_irq_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (irq_set != 4'h0 && (irq_set & ~irq_mask_reg) != 4'h0) |-> ##[1:2] O_CORE_IRQ)
    else $error("enabled request did not interrupt");
  edge_once_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (irq_edge_reg[0] && irq_act[0] && irq_prev_reg[0]) |-> !irq_set[0])
    else $error("edge input fired on steady level");
  boot_en_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $rose(strap_done_reg) |-> irq_en_reg == (strap_reg ? `FITP_IRQ_EN_BOOT : `FITP_IRQ_EN_RST))
    else $error("request enable wrong after reset");
  strap_nodrive_a: assert property (@(posedge I_CLK)
    !I_RST_N |=> !O_TMR_EXP_OE) else $error("expired pin driven in reset");
  sync_delay_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $changed(flag_in) |-> ((flag_in ^ $past(flag_in)) & (flag_in ^ $past(I_FLAG, 3))) == 4'h0)
    else $error("flag sync too fast");

endmodule

// File: shared/fitp_pkg.sv
/*
  types shared by the flag, interrupt-request and timer-expired pin block.
  assumes the constants header sits beside it on the include path.
*/
`include "fitp_regs.svh"

package fitp_pkg;

  typedef struct packed {
    logic                     wr;
    logic                     rd;
    logic [`FITP_ADDR_W-1:0]  addr;
    logic [31:0]              wdata;
  } fitp_bus_req_type;

  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] out;
  } fitp_flag_cfg_type;

  typedef enum logic [2:0] {
    FITP_T_STRAP = 3'b001,
    FITP_T_IDLE  = 3'b010,
    FITP_T_PULSE = 3'b100
  } fitp_tmr_state_type;

endpackage

// File: shared/fitp_regs.svh
/*
  register offsets, field positions, reset values and timing counts for the
  flag, interrupt-request and timer-expired pin block.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef FITP_REGS_SVH
`define FITP_REGS_SVH

`define FITP_ADDR_W          4
`define FITP_OFF_FLAG_DIR    4'h0
`define FITP_OFF_FLAG_OUT    4'h1
`define FITP_OFF_FLAG_IN     4'h2
`define FITP_OFF_IRQ_EN      4'h3
`define FITP_OFF_IRQ_EDGE    4'h4
`define FITP_OFF_IRQ_STAT    4'h5
`define FITP_OFF_IRQ_MASK    4'h6
`define FITP_OFF_TMR_CTRL    4'h7
`define FITP_OFF_TMR_LOAD    4'h8
`define FITP_OFF_STRAP       4'h9
`define FITP_OFF_EVT_STAT    4'ha
`define FITP_OFF_EVT_MASK    4'hb

`define FITP_FLAG_DIR_RST    4'h0
`define FITP_FLAG_OUT_RST    4'h0
`define FITP_IRQ_EN_RST      4'h0
`define FITP_IRQ_EN_BOOT     4'hf
`define FITP_IRQ_EDGE_RST    4'h0
`define FITP_MASK_RST        4'h0
`define FITP_TMR_LOAD_RST    32'h0000_ffff

`define FITP_TMR_RUN_BIT     0
`define FITP_EVT_TMR_BIT     0
`define FITP_EVT_IRQ_BIT     1

`define FITP_TMR_PULSE_CYC   3'h4

`endif

// File: sim/fitp_ext.sv
/*
  far-side system logic: drives the flag inputs, the request lines and the
  boot strap, and resolves the shared pin levels.
  assumes pull-downs on flags and the expired pin, pull-ups on requests.
*/
`timescale 1ns/1ps

module fitp_ext (
  // from the device
  input  wire logic [3:0] i_flag_o,
  input  wire logic [3:0] i_flag_oe,
  input  wire logic       i_tmr_o,
  input  wire logic       i_tmr_oe,
  // board stimulus
  input  wire logic [3:0] i_ext_flag,
  input  wire logic [3:0] i_ext_en,
  input  wire logic [3:0] i_irq_act,
  input  wire logic       i_strap,
  // pin levels
  output logic      [3:0] o_flag_pin,
  output logic      [3:0] o_irq_n_pin,
  output logic            o_tmr_pin
);
  always_comb begin
    // a released flag falls to its pull-down
    o_flag_pin  = (i_flag_oe & i_flag_o) | (~i_flag_oe & i_ext_en & i_ext_flag);
    o_irq_n_pin = ~i_irq_act;
    // the strap is only seen while the device leaves the pin alone
    o_tmr_pin   = i_tmr_oe ? i_tmr_o : i_strap;
  end
endmodule

// File: sim/tb_top.sv
/*
  self-checking bench for the flag, request and timer-expired pin block.
  assumes the far-side model and the design files are compiled before it.
*/
`timescale 1ns/1ps

module tb_top;
  import fitp_pkg::*;

  logic        clk = 1'b0;
  logic        rst_n, wr, rd, tmr_o, tmr_oe, tmr_pin, strap, boot, core_irq, evt_irq;
  logic [3:0]  addr, flag_o, flag_oe, flag_pin, irq_n_pin, ext_flag, ext_en, irq_act, d, o, e, m;
  logic [31:0] wdata, rdata;
  int          n_errors, checked, run_len, cyc;
  int          rises[$];

  always #5 clk = ~clk;

  fitp_top fitp_top_inst (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_FLAG(flag_pin), .O_FLAG(flag_o), .O_FLAG_OE(flag_oe),
    .I_IRQ_N(irq_n_pin), .O_CORE_IRQ(core_irq), .I_TMR_EXP(tmr_pin), .O_TMR_EXP(tmr_o),
    .O_TMR_EXP_OE(tmr_oe), .O_STRAP_IRQ_BOOT(boot), .O_IRQ(evt_irq));

  fitp_ext fitp_ext_inst (
    .i_flag_o(flag_o), .i_flag_oe(flag_oe), .i_tmr_o(tmr_o), .i_tmr_oe(tmr_oe),
    .i_ext_flag(ext_flag), .i_ext_en(ext_en), .i_irq_act(irq_act), .i_strap(strap),
    .o_flag_pin(flag_pin), .o_irq_n_pin(irq_n_pin), .o_tmr_pin(tmr_pin));

  task automatic stop_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cwait(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    cwait(16);
    chk({tmr_oe, flag_oe}, 32'h0);
    rst_n <= 1'b1;
    cwait(3);
    #1;
    chk(boot, s);
    chk(flag_oe, 4'h0);
    rd_chk(4'h3, s ? 32'hf : 32'h0);
    rd_chk(4'h0, 32'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    {wr, rd, strap} = '0;
    {addr, ext_flag, ext_en, irq_act} = '0;
    wdata = '0;
    void'($urandom(52192));
    do_reset(1'b0);
    // random directions, drive values and far-side levels
    repeat (6) begin
      d = 4'($urandom);
      o = 4'($urandom);
      e = 4'($urandom);
      wr_reg(4'h0, {28'h0, d});
      wr_reg(4'h1, {28'h0, o});
      ext_flag <= e;
      ext_en   <= ~d;
      cwait(6);
      #1;
      chk(flag_oe, d);
      chk(flag_o, o & d);
      rd_chk(4'h2, {28'h0, (d & o) | (~d & e)});
      ext_flag <= ~e;
      rd_chk(4'h2, {28'h0, (d & o) | (~d & e)});
    end
    wr_reg(4'hf, 32'h0);
    rd_chk(4'hc, 32'h0);
    rd_chk(4'h0, {28'h0, d});
    // second reset in mid-run with the boot strap set
    do_reset(1'b1);
    wr_reg(4'h6, 32'h0);
    m = 4'($urandom);
    // two passes so every request input sees both detection kinds
    repeat (2) begin
      wr_reg(4'h4, {28'h0, m});
      for (int i = 0; i < 4; i++) begin
        irq_act <= 4'h1 << i;
        cwait(8);
        rd_chk(4'h5, 32'h1 << i);
        chk(core_irq, 1'b1);
        wr_reg(4'h5, 32'hf);
        rd_chk(4'h5, m[i] ? 32'h0 : 32'h1 << i);
        irq_act <= 4'h0;
        cwait(6);
        wr_reg(4'h5, 32'hf);
        rd_chk(4'h5, 32'h0);
        chk(core_irq, 1'b0);
      end
      m = ~m;
    end
    wr_reg(4'h3, 32'h0);
    irq_act <= 4'hf;
    cwait(8);
    rd_chk(4'h5, 32'h0);
    chk(core_irq, 1'b0);
    irq_act <= 4'h0;
    cwait(6);
    // timer with a short period
    wr_reg(4'h8, 32'h8);
    wr_reg(4'ha, 32'h3);
    wr_reg(4'hb, 32'h0);
    wr_reg(4'h7, 32'h1);
    repeat (60) begin
      @(negedge clk);
      cyc++;
      if (tmr_o === 1'b1) begin
        run_len++;
        if (run_len == 1) rises.push_back(cyc);
      end else if (run_len != 0) begin
        chk(run_len, 4);
        run_len = 0;
      end
    end
    chk(tmr_oe, 1'b1);
    chk(rises.size() >= 5, 1'b1);
    for (int k = 1; k < rises.size(); k++) chk(rises[k] - rises[k-1], 9);
    wr_reg(4'h7, 32'h0);
    rd_chk(4'ha, 32'h1);
    chk(evt_irq, 1'b1);
    wr_reg(4'hb, 32'h1);
    cwait(2);
    #1;
    chk(evt_irq, 1'b0);
    wr_reg(4'ha, 32'h1);
    rd_chk(4'ha, 32'h0);
    stop_test;
  end

  // the whole run takes well under a thousand cycles; allow twenty thousand
  initial begin
    #200000;
    n_errors++;
    stop_test;
  end
endmodule
